// ---- tb_zero_suppression_encoder.sv ----
/*
 * Self-checking bench: registers over AHB-Lite, events in, words checked in order.
 * Assumes zse_readout_model drives the output ready.
 */
`timescale 1ns/100ps
module tb_zero_suppression_encoder;
    import zse_pkg::*;
    logic        clk, arst_n, hwrite, dvalid, dlast, slow, rd_dp, hrdy, dready, wvalid, wlast;
    logic        wready, hresp;
    logic [31:0] haddr, hwdata, hrdata, word;
    logic [1:0]  htrans;
    logic [63:0] data;
    logic [63:0] dat[16];
    logic [32:0] word_q[$];
    logic [31:0] reg_q[$];
    int          seed, n_fail, num_checks, n;

    zse_encoder dut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_hsel(1'b1), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
        .i_data_valid(dvalid), .i_data(data), .i_data_last(dlast), .o_data_ready(dready),
        .o_word_valid(wvalid), .o_word(word), .o_word_last(wlast), .i_word_ready(wready));
    zse_readout_model u_rd (.i_ref_clk(clk), .i_slow(slow), .o_word_ready(wready));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic bad(input string m);
        n_fail++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask

    task automatic hang();
        bad("wait limit");
        print_verdict();
    endtask

    task automatic cmp_word(input logic [32:0] got);
        num_checks++;
        if (word_q.size() == 0 || word_q[0] !== got)
            bad($sformatf("word %h", got));
        if (word_q.size() != 0)
            void'(word_q.pop_front());
    endtask

    task automatic cmp_reg(input logic [31:0] got);
        num_checks++;
        if (reg_q.size() == 0 || reg_q[0] !== got)
            bad($sformatf("register %h", got));
        if (reg_q.size() != 0)
            void'(reg_q.pop_front());
    endtask

    // Results are checked where they appear, in the order they were noted.
    always @(posedge clk)
    begin
        if (wvalid === 1'b1 && wready === 1'b1)
            cmp_word({wlast, word});
        if (rd_dp === 1'b1 && hrdy === 1'b1)
            cmp_reg(hrdata);
    end

    task automatic wait_rdy();
        int k;
        k = 0;
        @(posedge clk);
        while (hrdy !== 1'b1 && k < 50)
        begin
            @(posedge clk);
            k++;
        end
        if (k == 50)
            hang();
    endtask

    // For a read, d is the expected data.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        rd_dp  <= ~w;
        if (!w)
            reg_q.push_back(d);
        wait_rdy();
        rd_dp <= 1'b0;
    endtask

    // Hit data put one sample on the exact threshold edge; the rest stay on the other side.
    task automatic fill(input logic [15:0] m, input bit ng, input int cnt);
        int h;
        n = cnt;
        for (int i = 0; i < cnt; i++)
        begin
            h = {$random(seed)} % 4;
            dat[i] = '0;
            for (int s = 0; s < 4; s++)
                dat[i][16*s +: 12] = (m[i] && s == h) ? (ng ? 12'h7FF : 12'h800)
                                                      : {ng, 11'($random(seed))};
        end
    endtask

    // Kind per datum: 0 dropped, 1 hit or look-forward, 2 look-back only; lim caps control words.
    task automatic expect_event(input bit zone_length_encoding, input logic [15:0] m, input int lb, input int lf,
                                input int ns, input int lim);
        int          kp[16];
        logic [31:0] w[$];
        int          i, j, best, run, nc;
        best = 0;
        run = 0;
        nc = 0;
        for (i = 0; i < n; i++)
        begin
            run = m[i] ? run + 1 : 0;
            best = (run > best) ? run : best;
            kp[i] = zone_length_encoding ? 0 : 1;
            for (j = 0; j < n; j++)
                if (m[j] && i >= j && i <= j + lf)
                    kp[i] = 1;
                else if (m[j] && i >= j - lb && i < j && kp[i] == 0)
                    kp[i] = 2;
        end
        i = 0;
        while (i < n && (zone_length_encoding || best >= ns))
        begin
            j = i + 1;
            nc++;
            if (nc == lim)
            begin
                kp[i] = 1;
                j = n;
            end
            while (j < n && (kp[j] == 0) == (kp[i] == 0) && !(kp[j] == 2 && kp[j - 1] == 1))
                j++;
            if (zone_length_encoding)
                w.push_back({kp[i] != 0, 1'b1, 9'h0, 21'(2 * (j - i))});
            for (int k = i; k < j && kp[i] != 0; k++)
            begin
                w.push_back(dat[k][31:0]);
                w.push_back(dat[k][63:32]);
            end
            i = j;
        end
        if (zone_length_encoding)
            w.push_front(32'(w.size() + 1));
        foreach (w[k])
            word_q.push_back({k == w.size() - 1, w[k]});
    endtask

    task automatic send();
        int k;
        for (int i = 0; i < n; i++)
        begin
            dvalid <= 1'b1;
            data   <= dat[i];
            dlast  <= (i == n - 1);
            k = 0;
            @(posedge clk);
            while (dready !== 1'b1 && k < 3000)
            begin
                @(posedge clk);
                k++;
            end
            if (k == 3000)
                hang();
        end
        dvalid <= 1'b0;
        dlast  <= 1'b0;
        @(posedge clk);
        for (k = 0; k < 3000 && (word_q.size() != 0 || dready !== 1'b1); k++)
            @(posedge clk);
        if (k == 3000)
            hang();
    endtask

    initial
    begin
        int          lb, lf;
        logic [15:0] m;
        seed   = 32'h11AF;
        arst_n = 1'b0;
        {hwrite, dvalid, dlast, slow, rd_dp} = '0;
        {haddr, hwdata, data, htrans} = '0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(0, ADDR_NSAMP, 32'(NSAMP_RST));
        bus(0, ADDR_THRESH, THRESH_RST);
        bus(1, 8'h20, 32'hFFFF_FFFF);
        bus(0, 8'h20, 32'h0);
        bus(1, ADDR_CTRL, 32'h3);
        for (int e = 0; e < 10; e++)
        begin
            lb = {$random(seed)} % 3;
            lf = {$random(seed)} % 3;
            m = 16'((1 + {$random(seed)} % 2) * 3 / 2) << ({$random(seed)} % 8);
            slow <= e[1];
            bus(1, ADDR_THRESH, {e[0], 19'h0, 12'h800});
            bus(1, ADDR_LOOK, {16'h0, 8'(lf), 8'(lb)});
            fill(m, e[0], 10);
            expect_event(1'b1, m, lb, lf, 0, 99);
            send();
        end
        bus(1, ADDR_THRESH, 32'h0000_0800);
        bus(1, ADDR_LOOK, 32'h0000_0102);
        fill(16'h0012, 1'b0, 10);
        expect_event(1'b1, 16'h0012, 2, 1, 0, 99);
        send();
        bus(1, ADDR_LOOK, 32'h0);
        bus(1, ADDR_CTRL, 32'hB);
        fill(16'h5555, 1'b0, 16);
        expect_event(1'b1, 16'h5555, 0, 0, 0, 14);
        send();
        // Only the fifth packed sample crosses, so normal packing would see nothing.
        bus(1, ADDR_CTRL, 32'h7);
        dat[0] = '0;
        dat[1] = 64'h2000_0000_0000_0000;
        dat[2] = '0;
        n = 3;
        expect_event(1'b1, 16'h0002, 0, 0, 0, 99);
        send();
        bus(1, ADDR_CTRL, 32'h2);
        bus(1, ADDR_NSAMP, 32'h2);
        for (int g = 0; g < 2; g++)
        begin
            bus(1, ADDR_THRESH, {g[0], 19'h0, 12'h800});
            fill(16'h0014, g[0], 6);
            send();
            bus(0, ADDR_STATUS, {16'(g + 1), 9'h0, 7'h01});
            fill(16'h000C, g[0], 6);
            expect_event(1'b0, 16'h000C, 0, 0, 2, 99);
            send();
        end
        print_verdict();
    end
endmodule

// ---- zse_encoder.sv ----
/*
 * One channel of the zero suppression encoder: captures an event of 64-bit data,
 * then either passes it whole or drops it (amplitude mode), or emits a framed
 * zone-length encoded event as 32-bit words. Registers sit on AHB-Lite.
 * Assumes the sample buffer and readout buffer share i_ref_clk and use
 * valid/ready handshakes; inputs are synchronous to the clock.
 */
// The implementer's own choices: the AHB-Lite register port and the register addresses.
// How it works
// - Control bit picks amplitude or zone encoding.
// - Compare per 64-bit datum, four or five samples.
// - Threshold bit 31 selects comparison polarity.
// - Positive: any sample at or above threshold.
// - Negative: any sample strictly below threshold.
// - Positive amplitude: drop event without long run.
// - Negative amplitude: drop event without low run.
// - Zone encoding drops out-of-zone data.
// - Keep look-back data before each zone.
// - Keep look-forward data after each zone.
// - Size word first, then control words, data.
// - Size counts every word including itself.
// - Control word: good, format, zeros, count.
// - Good control word followed by its data.
// - Skip control word followed by good one.
// - At most 62 control words, 14 old.
// - After limit, remaining data all stored.
// - Margins clipped by skip zones and bounds.
// - Overlapping margins give two good words.
// - Negative polarity only inverts the comparison.
`timescale 1ns/100ps
module zse_encoder
    import zse_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    input  wire logic        i_data_valid,
    input  wire logic [63:0] i_data,
    input  wire logic        i_data_last,
    output logic             o_data_ready,
    output logic             o_word_valid,
    output logic      [31:0] o_word,
    output logic             o_word_last,
    input  wire logic        i_word_ready
);
    typedef struct packed {
        zse_state_t        state;
        logic [IDX_W-1:0]  ptr;
        logic [IDX_W-1:0]  cnt;
        logic [7:0]        bc;
        logic [7:0]        fc;
        logic [20:0]       run;
        logic              met;
        logic [1:0]        pkind;
        logic [SEG_W-1:0]  nseg;
        logic [IDX_W-1:0]  clen;
        logic              lock;
        logic [31:0]       size;
        logic [SEG_W-1:0]  seg_i;
        logic [IDX_W-1:0]  dleft;
        logic              half;
        logic              dready;
        logic              wvalid;
        logic [31:0]       word;
        logic              wlast;
        logic              is_ctrl;
        logic [3:0]        ctrl;
        logic [31:0]       thresh;
        logic [20:0]       nsamp;
        logic [15:0]       look;
        logic [15:0]       dropped;
        logic              a_wr;
        logic [7:0]        a_addr;
        logic [31:0]       hrdata;
        logic              hready;
    } zse_st_t;

    zse_st_t          s;
    zse_st_t          next_s;
    logic [1:0]       rst_sync;
    logic             rst_n;
    logic [63:0]      mem [DEPTH];
    logic             over_m [DEPTH];
    logic             back_m [DEPTH];
    logic [IDX_W-1:0] seg_len [SEG_DEPTH];
    logic             seg_good [SEG_DEPTH];
    logic             mem_we;
    logic             back_we;
    logic             seg_we;
    logic [SEG_W-1:0] seg_wi;
    logic [IDX_W-1:0] seg_wlen;
    logic             seg_wgood;
    logic             hit_in;

    // Zone match of one datum; negative polarity only flips the comparison.
    function automatic logic zse_hit(input logic [63:0] d, input logic dense,
                                     input logic [31:0] thr);
        logic [59:0] packed5;
        logic [11:0] smp;
        logic        h;
        packed5 = {d[61:32], d[29:0]};
        h       = 1'b0;
        for (int k = 0; k < 5; k++)
        begin
            smp = dense ? packed5[k*SMP_W +: SMP_W] : d[k*16 +: SMP_W];
            if (dense || k < 4)
            begin
                if (thr[THR_NEG])
                    h = h | (smp < thr[SMP_W-1:0]);
                else
                    h = h | (smp >= thr[SMP_W-1:0]);
            end
        end
        return h;
    endfunction

    always_ff @(posedge i_ref_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    assign hit_in = zse_hit(i_data, s.ctrl[CTRL_DENSE], s.thresh);

    always_comb
    begin
        logic             can;
        logic             fcov;
        logic             keep;
        logic [1:0]       kind;
        logic             newseg;
        logic [5:0]       limit;
        logic             hitm;
        logic [IDX_W-1:0] len;
        can       = !s.wvalid || i_word_ready;
        fcov      = 1'b0;
        keep      = 1'b0;
        kind      = 2'h0;
        newseg    = 1'b0;
        limit     = s.ctrl[CTRL_OLDREV] ? CW_LIMIT_OLD : CW_LIMIT_NEW;
        hitm      = over_m[s.ptr[7:0]];
        len       = seg_len[s.seg_i];
        next_s    = s;
        mem_we    = 1'b0;
        back_we   = 1'b0;
        seg_we    = 1'b0;
        seg_wi    = s.nseg;
        seg_wlen  = 9'h001;
        seg_wgood = 1'b1;
        next_s.wvalid = s.wvalid && !i_word_ready;

        // Register bus: read data is taken at the address phase, writes at the data phase.
        if (s.a_wr)
        begin
            case (s.a_addr)
                ADDR_CTRL:   next_s.ctrl   = i_hwdata[3:0];
                ADDR_THRESH: next_s.thresh = i_hwdata;
                ADDR_NSAMP:  next_s.nsamp  = i_hwdata[20:0];
                ADDR_LOOK:   next_s.look   = i_hwdata[15:0];
                default:     next_s.look   = s.look;
            endcase
        end
        next_s.a_wr = i_hsel && i_hready && i_htrans[1] && i_hwrite;
        next_s.a_addr = i_haddr[7:0];
        if (i_hsel && i_hready && i_htrans[1] && !i_hwrite)
        begin
            case (i_haddr[7:0])
                ADDR_CTRL:   next_s.hrdata = {28'h0, s.ctrl};
                ADDR_THRESH: next_s.hrdata = s.thresh;
                ADDR_NSAMP:  next_s.hrdata = {11'h0, s.nsamp};
                ADDR_LOOK:   next_s.hrdata = {16'h0, s.look};
                ADDR_STATUS: next_s.hrdata = {s.dropped, 9'h0, s.state};
                default:     next_s.hrdata = 32'h0;
            endcase
        end

        case (s.state)
            ST_CAPT:
            begin
                if (i_data_valid && s.dready)
                begin
                    mem_we = 1'b1;
                    next_s.ptr = s.ptr + 9'h001;
                    next_s.run = hit_in ? s.run + 21'h00_0001 : 21'h0;
                    if (hit_in && (s.run + 21'h00_0001) >= s.nsamp)
                        next_s.met = 1'b1;
                    if (i_data_last || s.ptr == 9'(DEPTH - 1))
                    begin
                        next_s.cnt = s.ptr + 9'h001;
                        next_s.half = 1'b0;
                        if (s.ctrl[CTRL_ZLE])
                        begin
                            next_s.state = ST_BACK;
                            next_s.ptr = s.ptr;
                            next_s.bc = 8'h0;
                        end
                        else if (next_s.met || s.nsamp == 21'h0)
                        begin
                            next_s.state = ST_RAW;
                            next_s.ptr = 9'h0;
                        end
                        else
                        begin
                            next_s.ptr = 9'h0;
                            next_s.dropped = s.dropped + 16'h0001;
                        end
                        next_s.run = 21'h0;
                        next_s.met = 1'b0;
                    end
                end
            end
            ST_RAW:
            begin
                if (can)
                begin
                    next_s.wvalid = 1'b1;
                    next_s.is_ctrl = 1'b0;
                    next_s.word = s.half ? mem[s.ptr[7:0]][63:32] : mem[s.ptr[7:0]][31:0];
                    next_s.wlast = s.half && s.ptr == s.cnt - 9'h001;
                    next_s.half = !s.half;
                    if (s.half)
                    begin
                        next_s.ptr = s.ptr + 9'h001;
                        if (s.ptr == s.cnt - 9'h001)
                        begin
                            next_s.state = ST_CAPT;
                            next_s.ptr = 9'h0;
                        end
                    end
                end
            end
            ST_BACK:
            begin
                // Walking backwards lets one counter mark the look-back margin.
                back_we = 1'b1;
                if (hitm)
                    next_s.bc = s.look[7:0];
                else if (s.bc != 8'h0)
                    next_s.bc = s.bc - 8'h01;
                if (s.ptr == 9'h0)
                begin
                    next_s.state = ST_FWD;
                    next_s.fc = 8'h0;
                    next_s.nseg = 6'h0;
                    next_s.lock = 1'b0;
                    next_s.size = 32'h1;
                end
                else
                    next_s.ptr = s.ptr - 9'h001;
            end
            ST_FWD:
            begin
                fcov = hitm || s.fc != 8'h0;
                next_s.fc = hitm ? s.look[15:LOOK_FWD_LSB] :
                            (s.fc != 8'h0 ? s.fc - 8'h01 : 8'h0);
                keep = fcov || back_m[s.ptr[7:0]];
                kind = !keep ? 2'h0 : (fcov ? 2'h1 : 2'h2);
                newseg = s.ptr == 9'h0 || ((kind == 2'h0) != (s.pkind == 2'h0)) ||
                         (kind == 2'h2 && s.pkind == 2'h1);
                if (s.lock)
                begin
                    kind = 2'h1;
                    newseg = 1'b0;
                end
                else if (newseg && s.nseg == limit - 6'h01)
                begin
                    kind = 2'h1;
                    next_s.lock = 1'b1;
                end
                seg_we = 1'b1;
                seg_wgood = kind != 2'h0;
                if (newseg)
                begin
                    next_s.nseg = s.nseg + 6'h01;
                    next_s.clen = 9'h001;
                end
                else
                begin
                    seg_wi = s.nseg - 6'h01;
                    seg_wlen = s.clen + 9'h001;
                    next_s.clen = seg_wlen;
                end
                next_s.size = s.size + {31'h0, newseg} + (kind != 2'h0 ? 32'h2 : 32'h0);
                next_s.pkind = kind;
                next_s.ptr = s.ptr + 9'h001;
                if (s.ptr == s.cnt - 9'h001)
                begin
                    next_s.state = ST_SIZE;
                    next_s.ptr = 9'h0;
                    next_s.seg_i = 6'h0;
                end
            end
            ST_SIZE:
            begin
                if (can)
                begin
                    next_s.wvalid = 1'b1;
                    next_s.is_ctrl = 1'b0;
                    next_s.word = s.size;
                    next_s.wlast = 1'b0;
                    next_s.state = ST_CTRL;
                end
            end
            ST_CTRL:
            begin
                if (can)
                begin
                    next_s.wvalid = 1'b1;
                    next_s.is_ctrl = 1'b1;
                    next_s.word = {seg_good[s.seg_i], 1'b1, 9'h0,
                                   11'h0, len, 1'b0};
                    next_s.wlast = !seg_good[s.seg_i] && s.seg_i == s.nseg - 6'h01;
                    next_s.dleft = len;
                    next_s.half = 1'b0;
                    if (seg_good[s.seg_i])
                        next_s.state = ST_DATA;
                    else
                    begin
                        next_s.ptr = s.ptr + len;
                        next_s.seg_i = s.seg_i + 6'h01;
                        if (s.seg_i == s.nseg - 6'h01)
                            next_s.state = ST_CAPT;
                        else
                            next_s.state = ST_CTRL;
                    end
                end
            end
            ST_DATA:
            begin
                if (can)
                begin
                    next_s.wvalid = 1'b1;
                    next_s.is_ctrl = 1'b0;
                    next_s.word = s.half ? mem[s.ptr[7:0]][63:32] : mem[s.ptr[7:0]][31:0];
                    next_s.wlast = s.half && s.dleft == 9'h001 && s.seg_i == s.nseg - 6'h01;
                    next_s.half = !s.half;
                    if (s.half)
                    begin
                        next_s.ptr = s.ptr + 9'h001;
                        next_s.dleft = s.dleft - 9'h001;
                        if (s.dleft == 9'h001)
                        begin
                            next_s.seg_i = s.seg_i + 6'h01;
                            next_s.state = (s.seg_i == s.nseg - 6'h01) ? ST_CAPT : ST_CTRL;
                        end
                    end
                end
            end
            default:
                next_s.state = ST_CAPT;
        endcase
        if (next_s.state == ST_CAPT && s.state != ST_CAPT)
            next_s.ptr = 9'h0;
        next_s.dready = next_s.state == ST_CAPT && next_s.ctrl[CTRL_EN];
    end

    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s        <= '0;
            s.state  <= ST_CAPT;
            s.thresh <= THRESH_RST;
            s.nsamp  <= NSAMP_RST;
            s.hready <= 1'b1;
        end
        else
            s <= next_s;
    end

    // The buffers carry no reset; every entry is written before it is read.
    always_ff @(posedge i_ref_clk)
    begin
        if (mem_we)
        begin
            mem[s.ptr[7:0]]    <= i_data;
            over_m[s.ptr[7:0]] <= hit_in;
        end
        if (back_we)
            back_m[s.ptr[7:0]] <= !over_m[s.ptr[7:0]] && s.bc != 8'h0;
        if (seg_we)
        begin
            seg_len[seg_wi]  <= seg_wlen;
            seg_good[seg_wi] <= seg_wgood;
        end
    end

    assign o_hrdata     = s.hrdata;
    assign o_hreadyout  = s.hready;
    assign o_hresp      = 1'b0;
    assign o_data_ready = s.dready;
    assign o_word_valid = s.wvalid;
    assign o_word       = s.word;
    assign o_word_last  = s.wlast;

    logic [31:0] chk_words;
    logic [31:0] chk_size;
    logic        chk_skip;
    logic        acc;
    assign acc = s.wvalid && i_word_ready;
    always_ff @(posedge i_ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chk_words <= 32'h0;
            chk_size  <= 32'h0;
            chk_skip  <= 1'b0;
        end
        else if (acc)
        begin
            chk_words <= s.wlast ? 32'h0 : chk_words + 32'h1;
            if (chk_words == 32'h0 && !s.is_ctrl)
                chk_size <= s.word;
            // A skip that ends an event must not leak into the next one.
            if (s.is_ctrl)
                chk_skip <= !s.word[CW_GOOD] && !s.wlast;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n);

    property p_ctrl_fmt;
        s.wvalid && s.is_ctrl |-> s.word[CW_NEWFMT] && s.word[29:21] == 9'h0;
    endproperty
    a_ctrl_fmt: assert property (p_ctrl_fmt) else $error("control word format");
    property p_even;
        s.wvalid && s.is_ctrl |-> !s.word[0] && s.word[20:1] != 20'h0;
    endproperty
    a_even: assert property (p_even) else $error("odd control count");
    property p_size;
        acc && s.wlast && s.ctrl[CTRL_ZLE] |-> chk_words + 32'h1 == chk_size;
    endproperty
    a_size: assert property (p_size) else $error("size word mismatch");
    property p_limit;
        s.state == ST_SIZE |-> s.nseg <= (s.ctrl[CTRL_OLDREV] ? CW_LIMIT_OLD : CW_LIMIT_NEW);
    endproperty
    a_limit: assert property (p_limit) else $error("too many control words");
    property p_lock;
        s.state == ST_FWD && s.lock |->
            s.nseg == (s.ctrl[CTRL_OLDREV] ? CW_LIMIT_OLD : CW_LIMIT_NEW);
    endproperty
    a_lock: assert property (p_lock) else $error("encoding stopped off the limit");
    property p_skip_good;
        s.wvalid && s.is_ctrl && chk_skip && chk_words != 32'h0 |-> s.word[CW_GOOD];
    endproperty
    a_skip_good: assert property (p_skip_good) else $error("skip after skip");
    property p_good_data;
        acc && s.is_ctrl && s.word[CW_GOOD] |=> s.state == ST_DATA || s.wvalid && !s.is_ctrl;
    endproperty
    a_good_data: assert property (p_good_data) else $error("good word without data");
    property p_drop;
        s.state == ST_CAPT && $past(s.state) == ST_CAPT && $past(i_data_valid && s.dready
            && i_data_last && !s.ctrl[CTRL_ZLE] && !s.met && !hit_in && s.nsamp != 21'h0)
            |-> s.dropped == $past(s.dropped) + 16'h0001;
    endproperty
    a_drop: assert property (p_drop) else $error("short event not dropped");
    property p_bus;
        o_hreadyout && !o_hresp;
    endproperty
    a_bus: assert property (p_bus) else $error("bus not ready");
endmodule

// ---- zse_pkg.sv ----
/*
 * Constants, register map and state encoding of the zero suppression encoder.
 * Assumes a 25 MHz single clock domain and a 32-bit AHB-Lite register bus.
 */
package zse_pkg;
    localparam int          DATA_W       = 64;
    localparam int          WORD_W       = 32;
    localparam int          SMP_W        = 12;
    localparam int          DEPTH        = 256;
    localparam int          IDX_W        = 9;
    localparam int          SEG_DEPTH    = 64;
    localparam int          SEG_W        = 6;
    localparam logic [5:0]  CW_LIMIT_NEW = 6'h3E;
    localparam logic [5:0]  CW_LIMIT_OLD = 6'h0E;
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_THRESH  = 8'h04;
    localparam logic [7:0]  ADDR_NSAMP   = 8'h08;
    localparam logic [7:0]  ADDR_LOOK    = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS  = 8'h10;
    localparam int          CTRL_ZLE     = 0;
    localparam int          CTRL_EN      = 1;
    localparam int          CTRL_DENSE   = 2;
    localparam int          CTRL_OLDREV  = 3;
    localparam int          THR_NEG      = 31;
    localparam int          LOOK_FWD_LSB = 8;
    localparam int          CW_GOOD      = 31;
    localparam int          CW_NEWFMT    = 30;
    localparam int          CW_CNT_W     = 21;
    localparam logic [31:0] THRESH_RST   = 32'h0000_0000;
    localparam logic [20:0] NSAMP_RST    = 21'h00_0001;

    typedef enum logic [6:0] {
        ST_CAPT = 7'h01,
        ST_RAW  = 7'h02,
        ST_BACK = 7'h04,
        ST_FWD  = 7'h08,
        ST_SIZE = 7'h10,
        ST_CTRL = 7'h20,
        ST_DATA = 7'h40
    } zse_state_t;
endpackage

// ---- zse_readout_model.sv ----
/*
 * Readout buffer model at the encoder's output stream.
 * Assumes one clock; when i_slow is set it stalls at random, like a busy buffer.
 */
`timescale 1ns/100ps
module zse_readout_model
(
    input  wire logic i_ref_clk,
    input  wire logic i_slow,
    output logic      o_word_ready
);
    int seed_rd = 32'h11AF;
    initial o_word_ready = 1'b0;
    always @(posedge i_ref_clk)
    begin
        o_word_ready <= i_slow ? 1'($random(seed_rd)) : 1'b1;
    end
endmodule
